// [bfhz_pkg.sv]
package bfhz_pkg;
	localparam logic [15:0] RAM_END = 16'hfdff;
	localparam logic [15:0] RAM_BASE_3K = 16'hf200;
	localparam logic [15:0] RAM_BASE_2K = 16'hf600;
	localparam logic [15:0] RAM_BASE_1K = 16'hfa00;
	localparam logic [15:0] BIT_AREA_BASE = 16'hfd00;
	localparam logic [15:0] BIT_AREA_END = 16'hfdff;
	localparam logic [15:0] PTR_AREA_BASE = 16'hfce0;
	localparam logic [15:0] PTR_AREA_END = 16'hfcfe;
	localparam logic [15:0] STACK_REACH = 16'h0020;
	localparam logic [15:0] BANK_SPAN = 16'h001e;
	localparam logic [7:0] MATCH_REG_MAX = 8'hef;
	localparam logic [7:0] OPERAND_LOW_MAX = 8'h7f;
	localparam logic [3:0] REG_FORM_HI = 4'hf;
	localparam logic [2:0] LOCK_RANGE_ONE = 3'h1;

	// internal_ram module size select
	typedef enum logic [1:0]
	{
		BFHZ_RAM_3K = 2'h0,
		BFHZ_RAM_2K = 2'h1,
		BFHZ_RAM_1K = 2'h2
	} bfhz_ram_size_t;

	// kind of the preceding write-back
	typedef enum logic [2:0]
	{
		BFHZ_WR_NONE = 3'h0,
		BFHZ_WR_INSN = 3'h1,
		BFHZ_WR_XFER = 3'h2,
		BFHZ_WR_PTR_INC = 3'h3,
		BFHZ_WR_REG_INC = 3'h4,
		BFHZ_WR_STACK = 3'h5
	} bfhz_wr_kind_t;

	// write-back seen during the execute cycle of the predecessor
	typedef struct packed
	{
		bfhz_wr_kind_t kind;
		logic [15:0] addr;
		logic is_reg;
		logic [3:0] reg_num;
		logic [15:0] data;
	} bfhz_wb_t;

	// bit-field load presented in decode
	typedef struct packed
	{
		logic valid;
		logic high_form;
		logic [7:0] third_byte;
		logic [15:0] operand;
		logic [15:0] result;
	} bfhz_bfl_t;

	// lock_prefix / extend sequence context of the load
	typedef struct packed
	{
		logic in_seq;
		logic [2:0] position;
		logic prev_is_lock_one;
	} bfhz_lock_t;
endpackage

// [bfhz_match.sv]
module bfhz_match
(
	// predecessor write and load
	input wire bfhz_pkg::bfhz_wb_t wb_i,
	input wire bfhz_pkg::bfhz_bfl_t bfl_i,
	// core context
	input wire logic [15:0] context_pointer_i,
	input wire logic [15:0] stack_pointer_i,
	input wire bfhz_pkg::bfhz_ram_size_t ram_size_i,
	// verdict
	output logic case_one_o,
	output logic case_two_o,
	output logic in_ram_o
)
;
	logic [15:0] ram_base;
	logic [15:0] reg_addr;
	logic [15:0] bit_addr;
	logic wr_reg_y;
	logic cp_over_ptr;
	logic stack_ok;

	always_comb
	begin
		case (ram_size_i)
			bfhz_pkg::BFHZ_RAM_2K: ram_base = bfhz_pkg::RAM_BASE_2K;
			bfhz_pkg::BFHZ_RAM_1K: ram_base = bfhz_pkg::RAM_BASE_1K;
			default: ram_base = bfhz_pkg::RAM_BASE_3K;
		endcase
	end

	// word address of general_register y, relative to context_pointer
	assign reg_addr = context_pointer_i + {11'h000, bfl_i.third_byte[3:0], 1'b0};
	assign bit_addr = bfhz_pkg::BIT_AREA_BASE + {7'h00, bfl_i.operand[7:0], 1'b0};
	assign in_ram_o = wb_i.is_reg || ((wb_i.addr >= ram_base) && (wb_i.addr <= bfhz_pkg::RAM_END));
	// byte writes hit the word either way, so bit 0 is ignored
	assign wr_reg_y = wb_i.is_reg ? (wb_i.reg_num == bfl_i.third_byte[3:0])
		: (wb_i.addr[15:1] == reg_addr[15:1]);
	assign cp_over_ptr = (context_pointer_i <= bfhz_pkg::PTR_AREA_END)
		&& ((context_pointer_i + bfhz_pkg::BANK_SPAN) >= bfhz_pkg::PTR_AREA_BASE);
	assign stack_ok = ((stack_pointer_i >= bfhz_pkg::BIT_AREA_BASE) && (stack_pointer_i <= bfhz_pkg::BIT_AREA_END))
		|| ((context_pointer_i < stack_pointer_i)
		&& ((stack_pointer_i - context_pointer_i) <= bfhz_pkg::STACK_REACH));

	always_comb
	begin
		case_one_o = 1'b0;
		case_two_o = 1'b0;
		case (wb_i.kind)
			bfhz_pkg::BFHZ_WR_INSN, bfhz_pkg::BFHZ_WR_XFER, bfhz_pkg::BFHZ_WR_REG_INC:
			begin
				case_one_o = (bfl_i.third_byte[7:4] == bfhz_pkg::REG_FORM_HI) && wr_reg_y;
				case_two_o = (bfl_i.third_byte <= bfhz_pkg::MATCH_REG_MAX)
					&& (bfl_i.operand[7:0] <= bfhz_pkg::OPERAND_LOW_MAX) && !wb_i.is_reg
					&& (wb_i.addr[15:1] == bit_addr[15:1]);
			end
			bfhz_pkg::BFHZ_WR_PTR_INC:
				case_one_o = (bfl_i.third_byte[7:4] == bfhz_pkg::REG_FORM_HI) && cp_over_ptr
					&& (wb_i.addr[15:1] == reg_addr[15:1]);
			bfhz_pkg::BFHZ_WR_STACK:
			begin
				case_one_o = stack_ok && (bfl_i.third_byte[7:4] == bfhz_pkg::REG_FORM_HI) && wr_reg_y;
				case_two_o = stack_ok && (bfl_i.third_byte <= bfhz_pkg::MATCH_REG_MAX)
					&& (bfl_i.operand[7:0] <= bfhz_pkg::OPERAND_LOW_MAX)
					&& (wb_i.addr[15:1] == bit_addr[15:1]);
			end
			default:
			begin
				case_one_o = 1'b0;
				case_two_o = 1'b0;
			end
		endcase
	end
endmodule

// [bfhz_core.sv]
// How it works
// - only internal_ram write-backs, range by size
// - only back-to-back decode with predecessor execute
// - third byte compared with write destination
// - 0Fy byte matches writes to register y
// - low byte v selects bit word
// - hazard ORs whole result with write data
// - implicit pointer, register, stack writes count
// - non-writing predecessors never cause hazard
// - pointer increment only in case one
// - stack writes only in two placements
// - lock prefix range one protects load
// - position one safe; repeated prefix protects
module bfhz_core
(
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// predecessor execute stage
	input wire logic exec_valid_i,
	input wire bfhz_pkg::bfhz_wb_t wb_i,
	// bit_field_load decode stage
	input wire bfhz_pkg::bfhz_bfl_t bfl_i,
	input wire bfhz_pkg::bfhz_lock_t lock_i,
	// core context
	input wire logic [15:0] context_pointer_i,
	input wire logic [15:0] stack_pointer_i,
	input wire bfhz_pkg::bfhz_ram_size_t ram_size_i,
	// result
	output logic result_valid_o,
	output logic [15:0] result_o,
	output logic hazard_o
)
;
	logic case_one;
	logic case_two;
	logic in_ram;
	logic back_to_back;
	logic protected_seq;
	logic hazard_nxt;
	logic result_valid_r;
	logic [15:0] result_r;
	logic hazard_r;
	logic [15:0] reg_slot;
	localparam logic [2:0] LOCK_RANGE_ONE_C = bfhz_pkg::LOCK_RANGE_ONE;

	bfhz_match u_match
	(
		.wb_i(wb_i),
		.bfl_i(bfl_i),
		.context_pointer_i(context_pointer_i),
		.stack_pointer_i(stack_pointer_i),
		.ram_size_i(ram_size_i),
		.case_one_o(case_one),
		.case_two_o(case_two),
		.in_ram_o(in_ram)
	);

	assign back_to_back = exec_valid_i && bfl_i.valid;
	// a lock range of one or a repeated prefix leaves no writer in the slot before the load
	assign protected_seq = lock_i.prev_is_lock_one
		|| (lock_i.in_seq && (lock_i.position == LOCK_RANGE_ONE_C));
	// word of register y in the active bank, kept only for the checks below
	assign reg_slot = context_pointer_i + {11'h000, bfl_i.third_byte[3:0], 1'b0};

	assign hazard_nxt = back_to_back && in_ram && !protected_seq
		&& (wb_i.kind != bfhz_pkg::BFHZ_WR_NONE) && (case_one || case_two);

	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			result_valid_r <= 1'b0;
			hazard_r <= 1'b0;
		end
		else
		begin
			result_valid_r <= bfl_i.valid;
			hazard_r <= hazard_nxt;
		end
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			result_r <= 16'h0000;
		end
		else if (bfl_i.valid)
		begin
			result_r <= hazard_nxt ? (bfl_i.result | wb_i.data) : bfl_i.result;
		end
	end

	assign result_valid_o = result_valid_r;
	assign result_o = result_r;
	assign hazard_o = hazard_r;

	a_reset_clears: assert property (@(posedge ref_clk_i) rst_i |=> !hazard_o && !result_valid_o)
		else $error("state not cleared by reset");
	a_or_result: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		hazard_nxt |=> result_o == ($past(bfl_i.result) | $past(wb_i.data)))
		else $error("hazard result not ORed");
	a_clean_result: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(bfl_i.valid && !hazard_nxt) |=> result_o == $past(bfl_i.result))
		else $error("clean result altered");
	a_need_b2b: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		!exec_valid_i |=> !hazard_o)
		else $error("hazard without back-to-back");
	a_lock_one: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		lock_i.prev_is_lock_one |=> !hazard_o)
		else $error("lock range one not protecting");
	a_seq_protect: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(lock_i.in_seq && lock_i.position == LOCK_RANGE_ONE_C) |=> !hazard_o)
		else $error("first load in sequence hit");
	a_ram_only: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		!in_ram |=> !hazard_o)
		else $error("hazard outside internal ram");
	a_no_writer: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		wb_i.kind == bfhz_pkg::BFHZ_WR_NONE |=> !hazard_o)
		else $error("hazard after non-writing predecessor");
	a_ptr_case_one: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(wb_i.kind == bfhz_pkg::BFHZ_WR_PTR_INC && bfl_i.third_byte[7:4] != bfhz_pkg::REG_FORM_HI) |=> !hazard_o)
		else $error("pointer increment outside case one");
	a_hazard_match: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		hazard_o |-> $past(case_one || case_two))
		else $error("hazard without address match");

	// a load in decode is answered on the next edge, with the hazard flag beside it
	sequence s_load_taken;
		bfl_i.valid;
	endsequence
	sequence s_answer_due;
		##1 result_valid_o;
	endsequence
	sequence s_hazard_taken;
		hazard_nxt;
	endsequence
	sequence s_hazard_shown;
		##1 (hazard_o && result_valid_o);
	endsequence
	sequence s_idle_slot;
		!bfl_i.valid;
	endsequence
	sequence s_quiet_next;
		##1 (!result_valid_o && !hazard_o);
	endsequence

	a_answer_due: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		s_load_taken |-> s_answer_due)
		else $error("load not answered next cycle");
	a_hazard_shown: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		s_hazard_taken |-> s_hazard_shown)
		else $error("hazard not flagged with its answer");
	a_idle_quiet: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		s_idle_slot |-> s_quiet_next)
		else $error("answer without a load");
	a_result_held: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		!bfl_i.valid |=> $stable(result_o))
		else $error("result changed without a load");
	a_hazard_answer: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		hazard_o |-> result_valid_o)
		else $error("hazard flag without answer");
	a_hazard_b2b: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		hazard_o |-> ($past(exec_valid_i) && $past(bfl_i.valid)))
		else $error("hazard without overlapped execute");
	a_hazard_kind: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		hazard_o |-> ($past(wb_i.kind) != bfhz_pkg::BFHZ_WR_NONE))
		else $error("hazard without a write");
	a_hazard_bits: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		hazard_o |-> ((result_o & $past(wb_i.data)) == $past(wb_i.data)))
		else $error("write data bits missing from result");
	a_protect_none: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		hazard_o |-> !$past(protected_seq))
		else $error("hazard inside a protected slot");
	// verdicts checked against the byte forms, not against the match module's own terms
	a_form_one: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		case_one |-> (bfl_i.third_byte[7:4] == bfhz_pkg::REG_FORM_HI))
		else $error("case one without register form");
	a_reg_number: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(case_one && wb_i.is_reg && (wb_i.kind != bfhz_pkg::BFHZ_WR_PTR_INC))
		|-> (wb_i.reg_num == bfl_i.third_byte[3:0]))
		else $error("case one on another register");
	a_reg_slot: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(case_one && !wb_i.is_reg) |-> (wb_i.addr[15:1] == reg_slot[15:1]))
		else $error("case one on another address");
	a_form_two: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		case_two |-> ((bfl_i.third_byte <= bfhz_pkg::MATCH_REG_MAX)
		&& (bfl_i.operand[7:0] <= bfhz_pkg::OPERAND_LOW_MAX)))
		else $error("case two outside its byte ranges");
	a_bit_word: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		case_two |-> ((wb_i.addr[15:8] == bfhz_pkg::BIT_AREA_BASE[15:8])
		&& (wb_i.addr[7:1] == bfl_i.operand[6:0])))
		else $error("case two on another bit word");
	a_cases_apart: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		!(case_one && case_two))
		else $error("both match cases at once");
	a_ptr_no_two: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(wb_i.kind == bfhz_pkg::BFHZ_WR_PTR_INC) |-> !case_two)
		else $error("pointer increment in case two");
	a_ptr_far: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		((wb_i.kind == bfhz_pkg::BFHZ_WR_PTR_INC) && (context_pointer_i > bfhz_pkg::PTR_AREA_END)) |=> !hazard_o)
		else $error("pointer increment hazard with bank above pointers");
	// the address window is judged from the write side, so register-addressed writes are left out
	a_ram_above: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(!wb_i.is_reg && (wb_i.addr > bfhz_pkg::RAM_END)) |=> !hazard_o)
		else $error("hazard above internal ram");
	a_ram_below: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(!wb_i.is_reg && (((ram_size_i == bfhz_pkg::BFHZ_RAM_3K) && (wb_i.addr < bfhz_pkg::RAM_BASE_3K))
		|| ((ram_size_i == bfhz_pkg::BFHZ_RAM_2K) && (wb_i.addr < bfhz_pkg::RAM_BASE_2K))
		|| ((ram_size_i == bfhz_pkg::BFHZ_RAM_1K) && (wb_i.addr < bfhz_pkg::RAM_BASE_1K)))) |=> !hazard_o)
		else $error("hazard below internal ram");
	// pushes reach the bank only from the bit area or from just above the bank
	a_stack_place: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		((wb_i.kind == bfhz_pkg::BFHZ_WR_STACK)
		&& !((stack_pointer_i >= bfhz_pkg::BIT_AREA_BASE) && (stack_pointer_i <= bfhz_pkg::BIT_AREA_END))
		&& !((context_pointer_i < stack_pointer_i)
		&& ((stack_pointer_i - context_pointer_i) <= bfhz_pkg::STACK_REACH))) |=> !hazard_o)
		else $error("stack write hazard outside its placements");
endmodule

// [bfhz_pipe_model.sv]
module bfhz_pipe_model
(
	// clock
	input wire logic ref_clk_i,
	// predecessor and load toward the hazard block
	output logic exec_valid_o,
	output bfhz_pkg::bfhz_wb_t wb_o,
	output bfhz_pkg::bfhz_bfl_t bfl_o,
	output bfhz_pkg::bfhz_lock_t lock_o
);
	timeunit 1ns;
	timeprecision 1ns;
	initial
	begin
		exec_valid_o = 1'b0;
		wb_o = '0;
		bfl_o = '0;
		lock_o = '0;
	end
	// load decode and predecessor execute share exactly one edge
	task automatic issue(input logic ex, input bfhz_pkg::bfhz_wb_t w, input bfhz_pkg::bfhz_bfl_t b,
		input bfhz_pkg::bfhz_lock_t l);
		bfhz_pkg::bfhz_wb_t r;
		bfhz_pkg::bfhz_bfl_t q;
		@(posedge ref_clk_i);
		exec_valid_o <= ex;
		wb_o <= w;
		bfl_o <= b;
		lock_o <= l;
		@(posedge ref_clk_i);
		// stale fields inverted so reading them outside the slot shows up
		r = ~w;
		r.kind = bfhz_pkg::BFHZ_WR_NONE;
		q = ~b;
		q.valid = 1'b0;
		exec_valid_o <= 1'b0;
		wb_o <= r;
		bfl_o <= q;
		lock_o <= ~l;
	endtask
endmodule

// [test_bitfield_write_hazard_model.sv]
module test_bitfield_write_hazard_model;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic ex = 1'b1;
	logic rg = 1'b0;
	logic [3:0] rn = 4'h0;
	logic [15:0] cp = 16'hfc00;
	logic [15:0] sp = 16'hfc40;
	bfhz_pkg::bfhz_ram_size_t sz = bfhz_pkg::BFHZ_RAM_3K;
	bfhz_pkg::bfhz_lock_t lk = '0;
	logic exv, rv, hz;
	bfhz_pkg::bfhz_wb_t wb;
	bfhz_pkg::bfhz_bfl_t bfl;
	bfhz_pkg::bfhz_lock_t lock;
	logic [15:0] res;
	int n_fail = 0;
	int checks = 0;
	int cyc = 0;
	initial forever #5 ref_clk_i = ~ref_clk_i;
	bfhz_pipe_model bfhz_pipe_model_inst(.ref_clk_i(ref_clk_i), .exec_valid_o(exv), .wb_o(wb), .bfl_o(bfl),
		.lock_o(lock));
	bfhz_core bfhz_core_inst(.ref_clk_i(ref_clk_i), .rst_i(rst_i), .exec_valid_i(exv), .wb_i(wb), .bfl_i(bfl),
		.lock_i(lock), .context_pointer_i(cp), .stack_pointer_i(sp), .ram_size_i(sz), .result_valid_o(rv),
		.result_o(res), .hazard_o(hz));
	task automatic close_out();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic ctx(input logic [15:0] c, input logic [15:0] s, input logic [1:0] z);
		@(posedge ref_clk_i);
		cp <= c;
		sp <= s;
		sz <= bfhz_pkg::bfhz_ram_size_t'(z);
	endtask
	// kinds: 1 insn, 2 transfer, 3 pointer inc, 4 register inc, 5 stack
	task automatic h(input logic [2:0] k, input logic [7:0] t, input logic [15:0] a, input logic [15:0] v,
		input logic e);
		bfhz_pkg::bfhz_wb_t w;
		bfhz_pkg::bfhz_bfl_t b;
		w = '{bfhz_pkg::bfhz_wr_kind_t'(k), a, rg, rn, 16'h0300};
		b = '{1'b1, t[0], t, v, 16'h0a05};
		bfhz_pipe_model_inst.issue(ex, w, b, lk);
		#1;
		chk({15'h0, rv}, 16'h0001);
		chk({15'h0, hz}, {15'h0, e});
		chk(res, e ? 16'h0b05 : 16'h0a05);
	endtask
	task automatic s_reset();
		repeat (20) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		@(posedge ref_clk_i);
		#1;
		chk({14'h0, rv, hz}, 16'h0000);
		chk(res, 16'h0000);
	endtask
	task automatic s_match();
		ctx(16'hfc00, 16'hfc40, 2'h0);
		h(3'h1, 8'hf3, 16'hfc07, 16'h0000, 1'b1);
		h(3'h1, 8'hf3, 16'hfc08, 16'h0000, 1'b0);
		h(3'h2, 8'hef, 16'hfdfe, 16'h127f, 1'b1);
		h(3'h2, 8'h20, 16'hfd0a, 16'h0085, 1'b0);
		h(3'h0, 8'hf3, 16'hfc06, 16'h0000, 1'b0);
	endtask
	task automatic s_regform();
		ctx(16'hfc00, 16'hfc40, 2'h0);
		rg = 1'b1;
		rn = 4'h3;
		h(3'h1, 8'hf3, 16'h0000, 16'h0000, 1'b1);
		h(3'h1, 8'hf4, 16'h0000, 16'h0000, 1'b0);
		rg = 1'b0;
		rn = 4'h0;
	endtask
	task automatic s_exec();
		ex = 1'b0;
		h(3'h1, 8'hf3, 16'hfc06, 16'h0000, 1'b0);
		ex = 1'b1;
	endtask
	task automatic s_range();
		ctx(16'hf200, 16'hfc40, 2'h0);
		h(3'h1, 8'hf0, 16'hf200, 16'h0000, 1'b1);
		ctx(16'hf200, 16'hfc40, 2'h1);
		h(3'h1, 8'hf0, 16'hf200, 16'h0000, 1'b0);
		ctx(16'hfa00, 16'hfc40, 2'h2);
		h(3'h1, 8'hf1, 16'hfa02, 16'h0000, 1'b1);
		ctx(16'hf9e0, 16'hfc40, 2'h2);
		h(3'h1, 8'hff, 16'hf9fe, 16'h0000, 1'b0);
	endtask
	task automatic s_implicit();
		ctx(16'hfce0, 16'hfd0a, 2'h0);
		h(3'h3, 8'hf2, 16'hfce4, 16'h0000, 1'b1);
		h(3'h3, 8'h20, 16'hfd0a, 16'h0005, 1'b0);
		h(3'h4, 8'hf2, 16'hfce4, 16'h0000, 1'b1);
		h(3'h5, 8'h20, 16'hfd0a, 16'h0005, 1'b1);
		ctx(16'hfc00, 16'hfc40, 2'h0);
		h(3'h5, 8'hf3, 16'hfc06, 16'h0000, 1'b0);
		ctx(16'hfc00, 16'hfc20, 2'h0);
		h(3'h5, 8'hf3, 16'hfc06, 16'h0000, 1'b1);
	endtask
	task automatic s_lock();
		lk = '{1'b0, 3'h0, 1'b1};
		h(3'h1, 8'hf3, 16'hfc06, 16'h0000, 1'b0);
		lk = '{1'b1, 3'h1, 1'b0};
		h(3'h1, 8'hf3, 16'hfc06, 16'h0000, 1'b0);
		lk = '{1'b1, 3'h2, 1'b0};
		h(3'h1, 8'hf3, 16'hfc06, 16'h0000, 1'b1);
		lk = '0;
	endtask
	initial
	begin
		s_reset();
		s_match();
		s_regform();
		s_exec();
		s_range();
		s_implicit();
		s_lock();
		close_out();
	end
	always @(posedge ref_clk_i)
	begin
		cyc++;
		if (cyc == 2000)
		begin
			n_fail++;
			close_out();
		end
	end
endmodule
